/* File: design/interval_event_counter_pkg.sv */
// Functional notes
// - Each channel is an independent 16-bit counter with its own reload register.
// - Mode comes from the two lowest mode bits: timer, event, single-shot, PWM.
// - Single-shot mode halts counting on the underflow tick that follows zero, reloading the counter.
// - Timer mode counts down on one of four clock taps, reloads on underflow.
// - Timer mode underflows once every reload plus one source clocks.
// - Timer and event modes count only while the start flag is one.
// - Timer mode raises the interrupt request on each underflow.
// - Reading the count register returns the current counter value.
// - A write while stopped loads both reload register and counter.
// - A write while counting updates only the reload register.
// - Gating lets the input pin level enable or suspend timer counting.
// - Pulse output inverts the output pin on each timer underflow.
// - Channels 0 and 1 single-phase only; channels 2 to 4 also two-phase.
// - Event mode counts selected input pin edges or another timer's overflow.
// - Event direction comes from software or the output pin level.
// - Event mode requests on overflow or underflow and reloads unless free-run.
// - Event rate divided by FFFF minus n plus 1 up, n plus 1 down.
// - Free-run lets the counter wrap without reloading.
// - Pulse output inverts the output pin on each event overflow or underflow; the code leaves the pin undriven in event mode while MODE_DIRP_BIT is set.
`default_nettype none
package interval_event_counter_pkg;
    localparam int          CNT_W          = 16;
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  OFS_COUNT      = 4'h0;
    localparam logic [3:0]  OFS_MODE       = 4'h1;
    localparam logic [3:0]  OFS_START      = 4'h2;
    localparam logic [3:0]  OFS_STATUS     = 4'h3;
    localparam int          MODE_SEL_LSB   = 0;
    localparam int          MODE_GATE_BIT  = 2;
    localparam int          MODE_GLVL_BIT  = 3;
    localparam int          MODE_PULSE_BIT = 4;
    localparam int          MODE_FREE_BIT  = 5;
    localparam int          MODE_EDGE_BIT  = 6;
    localparam int          MODE_DIRP_BIT  = 7;
    localparam int          MODE_UP_BIT    = 8;
    localparam int          MODE_SRC_LSB   = 9;
    localparam int          MODE_TAP_LSB   = 11;
    localparam logic [12:0] MODE_RST       = 13'h0000;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam int          DIV_EIGHT      = 8;
    localparam int          DIV_THIRTYTWO  = 32;
    localparam int          SUB_DIV        = 32;
    typedef enum logic [1:0] {
        MODE_TIMER  = 2'h0,
        MODE_EVENT  = 2'h1,
        MODE_SHOT   = 2'h2,
        MODE_PWM    = 2'h3
    } op_mode_e;
    typedef enum logic [1:0] {
        SRC_PIN     = 2'h0,
        SRC_GRP_B   = 2'h1,
        SRC_NEIGH   = 2'h2
    } ev_src_e;
endpackage : interval_event_counter_pkg
`default_nettype wire

/* File: design/interval_event_counter_unit.sv */
// The register offsets and strobed register access were decided locally.
`default_nettype none
module interval_event_counter_unit #(
    parameter bit TWO_PHASE_OK = 1'b1
) (
    // Clock and reset
    input  wire logic                                        mclk,
    input  wire logic                                        nrst,
    // Register port
    input  wire logic [interval_event_counter_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]                                 reg_wdata,
    input  wire logic                                        reg_wr,
    input  wire logic                                        reg_rd,
    output logic      [15:0]                                 reg_rdata,
    // Count sources
    input  wire logic                                        subclock_tick,
    input  wire logic                                        group_b_third_timer,
    input  wire logic                                        neighbour_group_a_timer,
    // Pins
    input  wire logic                                        channel_input_pin,
    input  wire logic                                        channel_output_pin_in,
    output logic                                             channel_output_pin_out,
    output logic                                             channel_output_pin_oe_n,
    // Events
    output logic                                             wrap_event,
    output logic                                             irq_request
);
    import interval_event_counter_pkg::*;

    logic [15:0] counter;
    logic [15:0] reload;
    logic [12:0] mode_reg;
    logic        start;
    logic        pulse_q;
    logic        in_q;
    logic        out_q;
    logic [4:0]  div_cnt;
    logic [4:0]  sub_cnt;
    logic        sub_q;
    logic        tick;
    logic        up;
    logic        wrap;
    logic        hit_zero;
    logic        running;
    op_mode_e    op_mode;
    logic [1:0]  tap_sel;
    logic [1:0]  src_sel;

    assign op_mode = op_mode_e'(mode_reg[MODE_SEL_LSB +: 2]);
    assign tap_sel = mode_reg[MODE_TAP_LSB +: 2];
    assign src_sel = mode_reg[MODE_SRC_LSB +: 2];
    assign running = start;

    // Prescaler taps
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // Subclock divided by thirty-two
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sub_cnt <= 5'h00;
            sub_q   <= 1'b0;
        end else begin
            sub_q <= 1'b0;
            if (subclock_tick) begin
                sub_cnt <= sub_cnt + 5'h01;
                sub_q   <= (sub_cnt == 5'(SUB_DIV - 1));
            end
        end
    end

    // Pin history for edges
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            in_q  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            in_q  <= channel_input_pin;
            out_q <= channel_output_pin_in;
        end
    end

    // Count enable and direction
    always_comb begin
        logic in_rise;
        logic in_fall;
        logic out_rise;
        logic out_fall;
        logic tap;
        tap      = 1'b0;
        in_rise  = channel_input_pin & ~in_q;
        in_fall  = ~channel_input_pin & in_q;
        out_rise = channel_output_pin_in & ~out_q;
        out_fall = ~channel_output_pin_in & out_q;
        tick     = 1'b0;
        up       = 1'b0;
        case (tap_sel)
            2'h0:    tap = 1'b1;
            2'h1:    tap = (div_cnt[2:0] == 3'(DIV_EIGHT - 1));
            2'h2:    tap = (div_cnt == 5'(DIV_THIRTYTWO - 1));
            default: tap = sub_q;
        endcase
        case (op_mode)
            MODE_TIMER, MODE_SHOT: begin
                tick = tap;
                if (mode_reg[MODE_GATE_BIT] &&
                    (channel_input_pin != mode_reg[MODE_GLVL_BIT])) begin
                    tick = 1'b0;
                end
            end
            MODE_EVENT: begin
                if (TWO_PHASE_OK && mode_reg[MODE_DIRP_BIT] &&
                    src_sel == 2'h3) begin
                    tick = channel_output_pin_in & (in_rise | in_fall);
                    up   = in_rise;
                end else begin
                    case (ev_src_e'(src_sel))
                        SRC_PIN:   tick = mode_reg[MODE_EDGE_BIT] ? in_fall : in_rise;
                        SRC_GRP_B: tick = group_b_third_timer;
                        SRC_NEIGH: tick = neighbour_group_a_timer;
                        default:   tick = 1'b0;
                    endcase
                    up = mode_reg[MODE_DIRP_BIT] ? channel_output_pin_in
                                                 : mode_reg[MODE_UP_BIT];
                end
                if (out_rise | out_fall) begin
                    up = up;
                end
            end
            default: tick = 1'b0;
        endcase
        tick = tick & running;
    end

    assign hit_zero = (counter == COUNT_RST);
    assign wrap     = tick && (up ? (counter == COUNT_ALL_ONES) : hit_zero);

    // Counter and reload
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            counter <= COUNT_RST;
            reload  <= COUNT_RST;
        end else begin
            if (reg_wr && reg_addr == OFS_COUNT) begin
                reload <= reg_wdata;
            end
            if (reg_wr && reg_addr == OFS_COUNT && !start) begin
                counter <= reg_wdata;
            end else if (wrap) begin
                if (op_mode == MODE_EVENT && mode_reg[MODE_FREE_BIT]) begin
                    counter <= up ? COUNT_RST : COUNT_ALL_ONES;
                end else begin
                    counter <= reload;
                end
            end else if (tick) begin
                counter <= up ? counter + 16'h0001 : counter - 16'h0001;
            end
        end
    end

    // Mode and start
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_RST;
            start    <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFS_MODE) begin
                mode_reg <= reg_wdata[12:0];
            end
            if (reg_wr && reg_addr == OFS_START) begin
                start <= reg_wdata[0];
            end else if (op_mode == MODE_SHOT && tick && hit_zero) begin
                start <= 1'b0;
            end
        end
    end

    // Pulse output and request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pulse_q     <= 1'b0;
            wrap_event  <= 1'b0;
            irq_request <= 1'b0;
        end else begin
            wrap_event  <= wrap;
            irq_request <= wrap && (op_mode == MODE_TIMER ||
                                    op_mode == MODE_EVENT ||
                                    op_mode == MODE_SHOT);
            if (wrap && mode_reg[MODE_PULSE_BIT]) begin
                pulse_q <= ~pulse_q;
            end
        end
    end

    assign channel_output_pin_out  = pulse_q;
    assign channel_output_pin_oe_n = ~(mode_reg[MODE_PULSE_BIT] &&
                                       !(op_mode == MODE_EVENT && mode_reg[MODE_DIRP_BIT]));

    // Read data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_COUNT:  reg_rdata <= counter;
                OFS_MODE:   reg_rdata <= {3'h0, mode_reg};
                OFS_START:  reg_rdata <= {15'h0000, start};
                OFS_STATUS: reg_rdata <= {14'h0000, pulse_q, start};
                default:    reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    AST_IRQ_ON_WRAP: assert property (@(posedge mclk) disable iff (!nrst)
        wrap && op_mode == MODE_TIMER |=> irq_request)
        else $error("timer wrap gave no request");
    AST_RELOAD_AFTER_WRAP: assert property (@(posedge mclk) disable iff (!nrst)
        wrap && !mode_reg[MODE_FREE_BIT] && !reg_wr |=> counter == $past(reload))
        else $error("counter not reloaded");
    AST_HOLD_STOPPED: assert property (@(posedge mclk) disable iff (!nrst)
        !start && !reg_wr |=> $stable(counter))
        else $error("counter moved while stopped");
    AST_WRITE_STOPPED: assert property (@(posedge mclk) disable iff (!nrst)
        reg_wr && reg_addr == OFS_COUNT && !start |=> counter == $past(reg_wdata))
        else $error("stopped write missed counter");
    AST_WRITE_RUNNING: assert property (@(posedge mclk) disable iff (!nrst)
        reg_wr && reg_addr == OFS_COUNT |=> reload == $past(reg_wdata))
        else $error("write missed reload");
    AST_TOGGLE: assert property (@(posedge mclk) disable iff (!nrst)
        wrap && mode_reg[MODE_PULSE_BIT] |=> pulse_q != $past(pulse_q))
        else $error("pulse output not inverted");
    AST_SHOT_HALT: assert property (@(posedge mclk) disable iff (!nrst)
        op_mode == MODE_SHOT && tick && hit_zero && !reg_wr |=> !start)
        else $error("single shot kept running");
    AST_READ_COUNT: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd && reg_addr == OFS_COUNT |=> reg_rdata == $past(counter))
        else $error("count read mismatch");
    AST_FREE_WRAP: assert property (@(posedge mclk) disable iff (!nrst)
        wrap && up && op_mode == MODE_EVENT && mode_reg[MODE_FREE_BIT] && !reg_wr
        |=> counter == COUNT_RST)
        else $error("free-run did not wrap");
endmodule : interval_event_counter_unit
`default_nettype wire

/* File: dv/iecu_partner.sv */
`default_nettype none
module iecu_partner (
    // Control from the bench
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       fire,
    input  wire logic [1:0] kind,
    // Count sources
    output logic            channel_input_pin,
    output logic            group_b_third_timer,
    output logic            neighbour_group_a_timer,
    output logic            subclock_tick
);
    logic [2:0] hold;

    // Pin pulse four cycles high, overflow strobes one cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hold                    <= 3'h0;
            channel_input_pin       <= 1'b0;
            group_b_third_timer     <= 1'b0;
            neighbour_group_a_timer <= 1'b0;
            subclock_tick           <= 1'b0;
        end else begin
            subclock_tick           <= ~subclock_tick;
            group_b_third_timer     <= fire && (kind == 2'h1);
            neighbour_group_a_timer <= fire && (kind == 2'h2);
            if (fire && (kind == 2'h0)) begin
                hold <= 3'h4;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end
            channel_input_pin <= (fire && (kind == 2'h0)) || (hold > 3'h1);
        end
    end
endmodule : iecu_partner
`default_nettype wire

/* File: dv/interval_event_counter_unit_tb_top.sv */
`default_nettype none
module interval_event_counter_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import interval_event_counter_pkg::*;
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] rel;
        logic [1:0]  kind;
        logic [3:0]  np;
        logic        lvl;
        logic [1:0]  nirq;
        logic [15:0] cnt;
    } row_s;
    logic        mclk, nrst, reg_wr, reg_rd, fire, out_lvl, pin_in, pin_out, oe_n;
    logic        grp_b, neigh, sub_tick, in_pin, wrap_event, irq_request, pb;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d, e;
    logic [1:0]  kind;
    int          mismatches, cmp_count, cyc, irq_cnt, base, t0, t1, t2;
    int          divs [4] = '{1, DIV_EIGHT, DIV_THIRTYTWO, SUB_DIV * 2};
    row_s        rows [8] = '{
        '{16'h0281, 16'hFFFE, 2'h1, 4'h2, 1'b1, 2'h1, 16'hFFFE},
        '{16'h0201, 16'h0003, 2'h1, 4'h8, 1'b0, 2'h2, 16'h0003},
        '{16'h0501, 16'hFFFD, 2'h2, 4'h6, 1'b0, 2'h2, 16'hFFFD},
        '{16'h0001, 16'h0001, 2'h0, 4'h5, 1'b0, 2'h2, 16'h0000},
        '{16'h0051, 16'h0002, 2'h0, 4'h3, 1'b0, 2'h1, 16'h0002},
        '{16'h0321, 16'hFFFE, 2'h1, 4'h3, 1'b0, 2'h1, 16'h0001},
        '{16'h0421, 16'h0001, 2'h2, 4'h3, 1'b0, 2'h1, 16'hFFFE},
        '{16'h0601, 16'hFFFE, 2'h0, 4'h2, 1'b1, 2'h0, 16'hFFFE}};

    assign pin_in = oe_n ? out_lvl : pin_out;

    interval_event_counter_unit u_interval_event_counter_unit (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .subclock_tick(sub_tick),
        .group_b_third_timer(grp_b), .neighbour_group_a_timer(neigh),
        .channel_input_pin(in_pin), .channel_output_pin_in(pin_in),
        .channel_output_pin_out(pin_out), .channel_output_pin_oe_n(oe_n),
        .wrap_event(wrap_event), .irq_request(irq_request));

    iecu_partner u_iecu_partner (
        .mclk(mclk), .nrst(nrst), .fire(fire), .kind(kind), .channel_input_pin(in_pin),
        .group_b_third_timer(grp_b), .neighbour_group_a_timer(neigh), .subclock_tick(sub_tick));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (irq_request === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask : rd

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wait_irq(output int t);
        t = -100000;
        for (int i = 0; i < 4000 && t < 0; i++) begin
            @(negedge mclk);
            if (irq_request === 1'b1) t = cyc;
        end
    endtask : wait_irq

    task automatic pulse(input logic [1:0] k);
        @(posedge mclk);
        fire <= 1'b1;
        kind <= k;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask : pulse

    task automatic setup(input logic [15:0] m, input logic [15:0] c);
        wr(OFS_START, 16'h0000);
        wr(OFS_MODE, m);
        wr(OFS_COUNT, c);
        wr(OFS_START, 16'h0001);
    endtask : setup

    task automatic tally_and_finish();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {nrst, reg_wr, reg_rd, fire, out_lvl, kind, reg_addr, reg_wdata} = '0;
        {mismatches, cmp_count, cyc, irq_cnt} = '0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        chk_bit(oe_n, 1'b1);
        chk_bit(irq_request, 1'b0);
        rd(OFS_COUNT, d);
        chk_word(d, COUNT_RST);
        rd(OFS_MODE, d);
        chk_word(d, {3'h0, MODE_RST});
        $display("reset test done");
        foreach (rows[i]) begin
            wr(OFS_START, 16'h0000);
            wr(OFS_MODE, rows[i].mode);
            out_lvl <= rows[i].lvl;
            pb = pin_out;
            base = irq_cnt;
            setup(rows[i].mode, rows[i].rel);
            repeat (rows[i].np) pulse(rows[i].kind);
            wr(OFS_START, 16'h0000);
            rd(OFS_COUNT, d);
            chk_word(d, rows[i].cnt);
            chk_word(16'(irq_cnt - base), {14'h0, rows[i].nirq});
            if (rows[i].mode[MODE_PULSE_BIT]) begin
                chk_bit(pin_out, pb ^ rows[i].nirq[0]);
                chk_bit(oe_n, 1'b0);
            end
            $display("event row %0d done", i);
        end
        out_lvl <= 1'b0;
        for (int t = 0; t < 4; t++) begin
            setup(16'(t << MODE_TAP_LSB), 16'h0001);
            wait_irq(t0);
            wait_irq(t1);
            chk_word(16'(t1 - t0), 16'(2 * divs[t]));
        end
        $display("tap test done");
        setup(16'h0000, 16'h0005);
        wait_irq(t0);
        wr(OFS_COUNT, 16'h0002);
        wait_irq(t1);
        wait_irq(t2);
        chk_word(16'(t1 - t0), 16'h0006);
        chk_word(16'(t2 - t1), 16'h0003);
        wr(OFS_START, 16'h0000);
        rd(OFS_COUNT, d);
        repeat (20) @(posedge mclk);
        rd(OFS_COUNT, e);
        chk_word(e, d);
        $display("reload and stop test done");
        wr(OFS_COUNT, 16'h1234);
        wr(4'h5, 16'hFFFF);
        rd(4'h4, d);
        chk_word(d, 16'h0000);
        rd(OFS_COUNT, d);
        chk_word(d, 16'h1234);
        setup(16'(1 << MODE_GATE_BIT | 1 << MODE_GLVL_BIT), 16'h0100);
        repeat (20) @(posedge mclk);
        rd(OFS_COUNT, d);
        chk_word(d, 16'h0100);
        setup(16'(1 << MODE_GATE_BIT), 16'h0100);
        repeat (20) @(posedge mclk);
        rd(OFS_COUNT, d);
        chk_bit(d < 16'h0100, 1'b1);
        setup({14'h0, MODE_SHOT}, 16'h0003);
        repeat (30) @(posedge mclk);
        rd(OFS_STATUS, d);
        chk_bit(d[0], 1'b0);
        $display("register, gate and single-shot test done");
        tally_and_finish();
    end
endmodule : interval_event_counter_unit_tb_top
`default_nettype wire
